// >>> common/mtig_cfg.svh
// Offsets, field positions, reset values and timing counts of the gap block
`ifndef MTIG_CFG_SVH
`define MTIG_CFG_SVH

// Register byte offsets; the three aliases sit +4, +8, +c from the base
`define MTIG_OFS_GAP     8'h00
`define MTIG_OFS_GAP_CLR 8'h04
`define MTIG_OFS_GAP_SET 8'h08
`define MTIG_OFS_GAP_INV 8'h0c
`define MTIG_OFS_CTRL    8'h10
`define MTIG_OFS_STAT    8'h14
`define MTIG_OFS_GAPCNT  8'h18

// Gap field
`define MTIG_GAP_LSB 0
`define MTIG_GAP_W   7
`define MTIG_GAP_RST 7'h12

// Control fields
`define MTIG_CTRL_FD_BIT  0
`define MTIG_CTRL_SPD_BIT 1
`define MTIG_CTRL_FD_RST  1'b0
`define MTIG_CTRL_SPD_RST 1'b1

// Status fields
`define MTIG_STAT_REM_LSB  0
`define MTIG_STAT_HOLD_BIT 8
`define MTIG_STAT_SEND_BIT 9

// Nibble times added back on top of the gap field
`define MTIG_FD_ADD 8'h03
`define MTIG_HD_ADD 8'h06

// Timing
`define MTIG_CLK_NS     10
`define MTIG_NIB_NS_100 40
`define MTIG_NIB_NS_10  400
`define MTIG_NIB_CYC_100 ((`MTIG_NIB_NS_100 + `MTIG_CLK_NS - 1) / `MTIG_CLK_NS)
`define MTIG_NIB_CYC_10  ((`MTIG_NIB_NS_10 + `MTIG_CLK_NS - 1) / `MTIG_CLK_NS)

// Widths
`define MTIG_CNT_W 8
`define MTIG_DIV_W 6
`define MTIG_GCNT_W 16

`endif

// >>> common/mtig_pkg.sv
// Types shared by the transmit gap block
`include "mtig_cfg.svh"

package mtig_pkg;

   typedef enum logic [2:0] {
      MTIG_IDLE = 3'b001,
      MTIG_SEND = 3'b010,
      MTIG_GAP  = 3'b100
   } mtig_phase_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } mtig_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } mtig_apb_rsp_t;

   typedef struct packed {
      mtig_apb_rsp_t                rsp;
      logic [`MTIG_GAP_W-1:0]       gap;
      logic                         full_duplex;
      logic                         speed_100;
      mtig_phase_t                  phase;
      logic [`MTIG_DIV_W-1:0]       div;
      logic                         tick;
      logic                         start;
      logic [`MTIG_CNT_W-1:0]       load;
      logic [`MTIG_GCNT_W-1:0]      gap_count;
      logic                         tx_grant;
      logic                         tx_hold;
   } mtig_top_st_t;

endpackage

// >>> logic/mtig_gap_timer.sv
// Nibble-time down counter that times one inter-packet gap
`timescale 1ns/1ps
`include "mtig_cfg.svh"

module mtig_gap_timer #(
   parameter int CNT_W = `MTIG_CNT_W
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] load,
   input  wire logic             tick,
   output logic      [CNT_W-1:0] remaining,
   output logic                  busy,
   output logic                  done
);

   typedef struct packed {
      logic [CNT_W-1:0] remaining;
      logic             busy;
      logic             done;
   } mtig_tmr_st_t;

   mtig_tmr_st_t st;
   mtig_tmr_st_t next_st;

   // Largest load is the full field plus the half-duplex addition
   if (CNT_W < `MTIG_GAP_W + 1) begin : g_width_check
      $error("mtig_gap_timer: CNT_W too narrow for the gap field plus offset");
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (start) begin
         next_st.remaining = load;
         next_st.busy = (load != '0);
         next_st.done = (load == '0);
      end else if (st.busy && tick) begin
         next_st.remaining = st.remaining - 1'b1;
         if (st.remaining == CNT_W'(1)) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign remaining = st.remaining;
   assign busy = st.busy;
   assign done = st.done;

endmodule

// >>> logic/mtig_top.sv
// Transmit inter-packet gap control with its APB register file
//
// Overview of operation
// - Seven-bit gap field, upper bits read zero
// - Enforce minimum idle nibbles after each packet
// - Full duplex adds three nibble times back
// - Half duplex adds six nibble times back
// - Accept 16/32-bit accesses, ignore 8-bit writes
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "mtig_cfg.svh"

module mtig_top #(
   parameter int NIB_CYC_100 = `MTIG_NIB_CYC_100,
   parameter int NIB_CYC_10  = `MTIG_NIB_CYC_10
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire mtig_pkg::mtig_apb_req_t apb_req,
   output mtig_pkg::mtig_apb_rsp_t      apb_rsp,
   input  wire logic                    tx_req,
   input  wire logic                    tx_frame_end,
   output logic                         tx_grant,
   output logic                         tx_hold
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks

   if (NIB_CYC_100 < 1 || NIB_CYC_100 >= (1 << `MTIG_DIV_W)) begin : g_chk_100
      $error("mtig_top: NIB_CYC_100 out of divider range");
   end

   if (NIB_CYC_10 < 1 || NIB_CYC_10 >= (1 << `MTIG_DIV_W)) begin : g_chk_10
      $error("mtig_top: NIB_CYC_10 out of divider range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   localparam logic [`MTIG_DIV_W-1:0] DIV_LAST_100 = `MTIG_DIV_W'(NIB_CYC_100 - 1);
   localparam logic [`MTIG_DIV_W-1:0] DIV_LAST_10  = `MTIG_DIV_W'(NIB_CYC_10 - 1);

   mtig_pkg::mtig_top_st_t      st;
   mtig_pkg::mtig_top_st_t      next_st;

   logic                        setup_phase;
   logic                        access_done;
   logic                        strb_ok;
   logic                        addr_mapped;
   logic [31:0]                 lane_mask;
   logic [31:0]                 wbits;
   logic [31:0]                 read_word;
   logic [`MTIG_DIV_W-1:0]      div_last;
   logic [`MTIG_CNT_W-1:0]      tmr_remaining;
   logic                        tmr_busy;
   logic                        tmr_done;

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode helpers

   // Only whole words or aligned half words are legal widths
   function automatic logic legal_strobe(input logic [3:0] s);
      legal_strobe = (s == 4'hf) || (s == 4'h3) || (s == 4'hc);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == `MTIG_OFS_GAP) || (a == `MTIG_OFS_GAP_CLR) ||
                  (a == `MTIG_OFS_GAP_SET) || (a == `MTIG_OFS_GAP_INV) ||
                  (a == `MTIG_OFS_CTRL) || (a == `MTIG_OFS_STAT) ||
                  (a == `MTIG_OFS_GAPCNT);
   endfunction

   assign setup_phase = apb_req.psel && !apb_req.penable;
   assign access_done = apb_req.psel && apb_req.penable && st.rsp.pready;
   assign strb_ok     = legal_strobe(apb_req.pstrb);
   assign addr_mapped = is_mapped(apb_req.paddr);

   assign lane_mask = {{8{apb_req.pstrb[3]}}, {8{apb_req.pstrb[2]}},
                       {8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};
   assign wbits     = apb_req.pwdata & lane_mask;

   assign div_last = st.speed_100 ? DIV_LAST_100 : DIV_LAST_10;

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer

   always_comb begin
      read_word = 32'h0000_0000;
      case (apb_req.paddr)
         `MTIG_OFS_GAP,
         `MTIG_OFS_GAP_CLR,
         `MTIG_OFS_GAP_SET,
         `MTIG_OFS_GAP_INV: begin
            // Aliases read back the field itself; bits 31:7 stay zero
            read_word[`MTIG_GAP_LSB +: `MTIG_GAP_W] = st.gap;
         end
         `MTIG_OFS_CTRL: begin
            read_word[`MTIG_CTRL_FD_BIT]  = st.full_duplex;
            read_word[`MTIG_CTRL_SPD_BIT] = st.speed_100;
         end
         `MTIG_OFS_STAT: begin
            read_word[`MTIG_STAT_REM_LSB +: `MTIG_CNT_W] = tmr_remaining;
            read_word[`MTIG_STAT_HOLD_BIT] = st.tx_hold;
            read_word[`MTIG_STAT_SEND_BIT] = (st.phase == mtig_pkg::MTIG_SEND);
         end
         `MTIG_OFS_GAPCNT: begin
            read_word[`MTIG_GCNT_W-1:0] = st.gap_count;
         end
         default: begin
            read_word = 32'h0000_0000;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_st = st;
      next_st.tx_grant = 1'b0;
      next_st.start    = 1'b0;
      next_st.tick     = 1'b0;

      // Answer one cycle after setup, so every transfer completes with no wait state
      next_st.rsp.pready = setup_phase;
      if (setup_phase) begin
         next_st.rsp.prdata  = addr_mapped ? read_word : 32'h0000_0000;
         next_st.rsp.pslverr = !addr_mapped;
      end

      // Writes land only at the completing edge; 8-bit strobes leave all alone
      if (access_done && apb_req.pwrite && strb_ok && addr_mapped) begin
         case (apb_req.paddr)
            `MTIG_OFS_GAP: begin
               next_st.gap = (st.gap & ~lane_mask[`MTIG_GAP_W-1:0]) |
                             wbits[`MTIG_GAP_W-1:0];
            end
            `MTIG_OFS_GAP_CLR: begin
               next_st.gap = st.gap & ~wbits[`MTIG_GAP_W-1:0];
            end
            `MTIG_OFS_GAP_SET: begin
               next_st.gap = st.gap | wbits[`MTIG_GAP_W-1:0];
            end
            `MTIG_OFS_GAP_INV: begin
               next_st.gap = st.gap ^ wbits[`MTIG_GAP_W-1:0];
            end
            `MTIG_OFS_CTRL: begin
               if (apb_req.pstrb[0]) begin
                  next_st.full_duplex = apb_req.pwdata[`MTIG_CTRL_FD_BIT];
                  next_st.speed_100   = apb_req.pwdata[`MTIG_CTRL_SPD_BIT];
               end
            end
            `MTIG_OFS_GAPCNT: begin
               // Any legal write clears; a gap ending now still counts
               next_st.gap_count = '0;
            end
            default: begin
               next_st.gap_count = next_st.gap_count;
            end
         endcase
      end

      // Transmit sequencing
      unique case (st.phase)
         mtig_pkg::MTIG_IDLE: begin
            if (tx_req) begin
               next_st.tx_grant = 1'b1;
               next_st.phase    = mtig_pkg::MTIG_SEND;
            end
         end
         mtig_pkg::MTIG_SEND: begin
            if (tx_frame_end) begin
               // Duplex sampled here; a later change waits for the next gap
               next_st.start = 1'b1;
               next_st.load  = `MTIG_CNT_W'(st.gap) +
                               (st.full_duplex ? `MTIG_FD_ADD : `MTIG_HD_ADD);
               next_st.div   = '0;
               next_st.phase = mtig_pkg::MTIG_GAP;
            end
         end
         mtig_pkg::MTIG_GAP: begin
            // Nibble divider restarts at packet end so the gap starts on a boundary
            if (st.div == div_last) begin
               next_st.div  = '0;
               next_st.tick = 1'b1;
            end else begin
               next_st.div = st.div + 1'b1;
            end
            if (tmr_done) begin
               next_st.phase     = mtig_pkg::MTIG_IDLE;
               next_st.div       = '0;
               next_st.tick      = 1'b0;
               next_st.gap_count = next_st.gap_count + 1'b1;
            end
         end
      endcase

      // Held from packet end until the last gap nibble has elapsed
      next_st.tx_hold = (next_st.phase == mtig_pkg::MTIG_GAP);
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st             <= '0;
         st.gap         <= `MTIG_GAP_RST;
         st.full_duplex <= `MTIG_CTRL_FD_RST;
         st.speed_100   <= `MTIG_CTRL_SPD_RST;
         st.phase       <= mtig_pkg::MTIG_IDLE;
      end else begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gap timer

   mtig_gap_timer #(
      .CNT_W     (`MTIG_CNT_W)
   ) u_gap_timer (
      .pclk      (pclk),
      .presetn   (presetn),
      .start     (st.start),
      .load      (st.load),
      .tick      (st.tick),
      .remaining (tmr_remaining),
      .busy      (tmr_busy),
      .done      (tmr_done)
   );

   // Busy is not used, not even in status; the phase already mirrors it
   logic unused_busy;
   assign unused_busy = tmr_busy;

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from the state register

   assign apb_rsp  = st.rsp;
   assign tx_grant = st.tx_grant;
   assign tx_hold  = st.tx_hold;

endmodule

// >>> bench/mtig_monitor.sv
// Concurrent checks on the gap block ports
`timescale 1ns/1ps

module mtig_monitor #(
   parameter int NIB_CYC_100 = 4,
   parameter int NIB_CYC_10  = 40
) (
   input wire logic                    pclk,
   input wire logic                    presetn,
   input wire mtig_pkg::mtig_apb_req_t apb_req,
   input wire mtig_pkg::mtig_apb_rsp_t apb_rsp,
   input wire logic                    tx_req,
   input wire logic                    tx_frame_end,
   input wire logic                    tx_grant,
   input wire logic                    tx_hold
);
   localparam int NIB_MIN = (NIB_CYC_100 < NIB_CYC_10) ? NIB_CYC_100 : NIB_CYC_10;
   logic [15:0] hold_cnt;

   // Length of the current idle run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_cnt <= 16'h0000;
      end else begin
         hold_cnt <= tx_hold ? hold_cnt + 16'h0001 : 16'h0000;
      end
   end

   ////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence access_s;
      apb_req.psel && apb_req.penable && apb_rsp.pready;
   endsequence

   pready_next_a: assert property (setup_s |=> access_s) else $error("pready late");
   pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready long");
   upper_zero_a: assert property (apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 8'h00
      |-> apb_rsp.prdata[31:7] == 25'h0) else $error("upper bits set");
   misalign_err_a: assert property (setup_s ##0 apb_req.paddr[1:0] != 2'b00 |=> apb_rsp.pslverr)
      else $error("no slave error");
   grant_pulse_a: assert property (tx_grant |=> !tx_grant) else $error("grant long");
   grant_cause_a: assert property (tx_grant |-> $past(tx_req) && !$past(tx_hold)) else $error("bad grant");
   hold_cause_a: assert property ($rose(tx_hold) |-> $past(tx_frame_end)) else $error("bad hold");
   hold_min_a: assert property ($fell(tx_hold) |-> hold_cnt >= 16'(3 * NIB_MIN)) else $error("gap short");
   hold_no_grant_a: assert property (tx_hold |-> !tx_grant) else $error("grant in gap");
endmodule

// >>> bench/mtig_phy_model.sv
// Transmit path stand-in: requests, sends a frame, times the gap
`timescale 1ns/1ps

module mtig_phy_model (
   input  wire logic   pclk,
   input  wire logic   presetn,
   input  wire logic   go,
   input  wire logic   tx_grant,
   input  wire logic   tx_hold,
   output logic        tx_req,
   output logic        tx_frame_end,
   output logic        done,
   output logic [15:0] hold_len
);
   logic [1:0] st;
   logic [3:0] nib;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= 2'd0;
         nib <= 4'h0;
         tx_req <= 1'b0;
         tx_frame_end <= 1'b0;
         done <= 1'b0;
         hold_len <= 16'h0000;
      end else begin
         case (st)
            2'd0: if (go) begin
               tx_req <= 1'b1;
               done <= 1'b0;
               hold_len <= 16'h0000;
               st <= 2'd1;
            end
            // Request stays up until the grant is seen
            2'd1: if (tx_grant) begin
               tx_req <= 1'b0;
               nib <= 4'h0;
               st <= 2'd2;
            end
            2'd2: begin
               nib <= nib + 4'h1;
               if (nib == 4'h7) begin
                  tx_frame_end <= 1'b1;
                  st <= 2'd3;
               end
            end
            default: begin
               tx_frame_end <= 1'b0;
               if (tx_hold) begin
                  hold_len <= hold_len + 16'h0001;
               end else if (hold_len != 16'h0000) begin
                  done <= 1'b1;
                  st <= 2'd0;
               end
            end
         endcase
      end
   end
endmodule

// >>> bench/mac_tx_interpacket_gap_test.sv
// Self-checking bench for the transmit gap block
`timescale 1ns/1ps
`include "mtig_cfg.svh"

module mac_tx_interpacket_gap_test;
   // Short nibble times keep the 10 Mbps runs brief
   localparam int N100 = 1;
   localparam int N10  = 2;
   logic                    pclk = 1'b0;
   logic                    presetn = 1'b0;
   mtig_pkg::mtig_apb_req_t apb_req = '0;
   mtig_pkg::mtig_apb_rsp_t apb_rsp;
   logic                    tx_req;
   logic                    tx_frame_end;
   logic                    tx_grant;
   logic                    tx_hold;
   logic                    go = 1'b0;
   logic                    done;
   logic [15:0]             hold_len;
   logic [31:0]             rd;
   logic                    err;
   int                      num_errors = 0;
   int                      n_tests = 0;

   always #5 pclk = ~pclk;

   mtig_top #(.NIB_CYC_100(N100), .NIB_CYC_10(N10)) DUT (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .tx_req(tx_req), .tx_frame_end(tx_frame_end), .tx_grant(tx_grant), .tx_hold(tx_hold));
   mtig_phy_model phy (.pclk(pclk), .presetn(presetn), .go(go), .tx_grant(tx_grant), .tx_hold(tx_hold),
      .tx_req(tx_req), .tx_frame_end(tx_frame_end), .done(done), .hold_len(hold_len));

   ////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %0t got %h want %h", $time, got, exp);
         num_errors++;
      end
   endtask

   task automatic hang;
      $display("ERROR %0t wait ran out", $time);
      num_errors++;
      print_verdict();
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int i;
      @(posedge pclk);
      apb_req <= '{1'b1, 1'b0, w, a, d, s};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      i = 0;
      // Registered response: right after the edge it still shows what that edge sampled
      do begin
         @(posedge pclk);
         i++;
      end while (apb_rsp.pready !== 1'b1 && i < 20);
      if (apb_rsp.pready !== 1'b1) hang();
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask

   // Write through any alias, then read the field back
   task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [31:0] exp);
      apb(1'b1, a, d, s);
      apb(1'b0, `MTIG_OFS_GAP, 32'h0, 4'hf);
      chk(rd, exp);
   endtask

   task automatic gap_start;
      @(posedge pclk);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
   endtask

   // Gap length is checked with room for the fixed hand-off latency
   task automatic gap_wait(input int exp);
      int i;
      i = 0;
      do begin
         @(posedge pclk);
         #1;
         i++;
      end while (done !== 1'b1 && i < 500);
      if (done !== 1'b1) hang();
      n_tests++;
      if ($isunknown(hold_len) || hold_len < exp || hold_len > exp + 3) begin
         $display("ERROR %0t gap %0d want %0d", $time, hold_len, exp);
         num_errors++;
      end
   endtask

   task automatic gap_run(input logic [31:0] ctrl, input logic [31:0] gap, input int exp);
      apb(1'b1, `MTIG_OFS_CTRL, ctrl, 4'hf);
      apb(1'b1, `MTIG_OFS_GAP, gap, 4'hf);
      gap_start();
      gap_wait(exp);
   endtask

   ////////////////////////////////////////
   initial begin
      int i;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `MTIG_OFS_GAP, 32'h0, 4'hf);
      chk(rd, 32'h00000012);
      apb(1'b0, `MTIG_OFS_CTRL, 32'h0, 4'hf);
      chk(rd, 32'h00000002);
      wchk(`MTIG_OFS_GAP, 32'hffffffff, 4'hf, 32'h7f);
      wchk(`MTIG_OFS_GAP, 32'h15, 4'h1, 32'h7f);
      wchk(`MTIG_OFS_GAP, 32'h0a, 4'h3, 32'h0a);
      wchk(`MTIG_OFS_GAP_SET, 32'h01, 4'hf, 32'h0b);
      wchk(`MTIG_OFS_GAP_CLR, 32'h02, 4'h3, 32'h09);
      wchk(`MTIG_OFS_GAP_INV, 32'h0f, 4'hf, 32'h06);
      wchk(`MTIG_OFS_GAP_INV, 32'h0f, 4'h1, 32'h06);
      apb(1'b0, 8'h1c, 32'h0, 4'hf);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, 8'h02, 32'h7, 4'hf);
      chk({31'h0, err}, 32'h1);
      $display("register tests done");
      gap_run(32'h3, 32'h15, (21 + `MTIG_FD_ADD) * N100);
      gap_run(32'h2, 32'h12, (18 + `MTIG_HD_ADD) * N100);
      gap_run(32'h0, 32'h12, (18 + `MTIG_HD_ADD) * N10);
      gap_run(32'h3, 32'h00, `MTIG_FD_ADD * N100);
      // Duplex flips mid-gap; the running gap keeps its offset
      apb(1'b1, `MTIG_OFS_CTRL, 32'h1, 4'hf);
      apb(1'b1, `MTIG_OFS_GAP, 32'h15, 4'hf);
      gap_start();
      i = 0;
      do begin
         @(negedge pclk);
         i++;
      end while (tx_hold !== 1'b1 && i < 100);
      if (tx_hold !== 1'b1) hang();
      apb(1'b1, `MTIG_OFS_CTRL, 32'h0, 4'hf);
      // Status mid-gap: holding, not sending
      apb(1'b0, `MTIG_OFS_STAT, 32'h0, 4'hf);
      chk({30'h0, rd[`MTIG_STAT_SEND_BIT:`MTIG_STAT_HOLD_BIT]}, 32'h1);
      gap_wait((21 + `MTIG_FD_ADD) * N10);
      apb(1'b0, `MTIG_OFS_GAPCNT, 32'h0, 4'hf);
      chk(rd, 32'h5);
      $display("gap tests done");
      print_verdict();
   end
endmodule

bind mtig_top mtig_monitor #(.NIB_CYC_100(NIB_CYC_100), .NIB_CYC_10(NIB_CYC_10)) mon (.pclk(pclk),
   .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .tx_req(tx_req), .tx_frame_end(tx_frame_end),
   .tx_grant(tx_grant), .tx_hold(tx_hold));
